// ### hdl/asrc_top.v
// asrc_top.v: serial port receiver, register set and transmit control.
// assumes bus strobes and serial_in_pin are synchronous to core_clk.
//
// How it works
// - M bit picks 8 or 9 data bits
// - ninth bit captured with data load
// - full character loads buffer, sets full flag
// - standby bit blocks receiver interrupts; reset clears
// - idle-line wakeup after 10/11 high bits
// - address-mark wakeup on MSB equal one
// - wake bit selects method; reset keeps it
// - wakeup clears standby bit by hardware
// - sixteen samples per bit, start verified
// - noise flag set with full flag
// - zero stop bit sets framing error
// - word arriving with no room sets overrun
// - 10/11 high bits set idle flag
// - transmit empty enable gates empty flag
// - done enable gates transmit done flag
// - receive enable gates full or overrun
// - idle enable gates idle flag
// - transmit enable sends 10/11 ones preamble
// - receive enable off: receiver stops, flags kept
// - break sends zero groups, then one bit
// - ninth transmit bit loaded with data
// - reset keeps M, ninth bits, data
// - status read then data read clears
// - overrun wins over framing error
// - prescale 1/3/4/13, then divide 2^n
`timescale 1ns/1ps
`include "asrc_map.vh"

////////////////////////////////////////////////////////////////////////////////
module asrc_fifo #(
  parameter W  = 11,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire          core_clk,
  input  wire          reset_n,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [AW:0]   count;
  wire          push;
  wire          pop;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & !pop) begin
        count <= count + 1'b1;
      end else if (pop & !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module asrc_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // internal data bus
  input  wire [7:0] bus_addr,
  input  wire [7:0] bus_wdata,
  input  wire       bus_wr,
  input  wire       bus_rd,
  output reg  [7:0] bus_rdata,
  // interrupt request
  output reg        irq_req,
  // serial pins
  input  wire       serial_in_pin,
  output reg        serial_out_pin,
  output reg        serial_out_oe
);
  localparam RX_IDLE  = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA  = 3'b100;

  function maj3;
    input [2:0] v;
    maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  function dis3;
    input [2:0] v;
    dis3 = ~(&v) & (|v);
  endfunction

  // software-visible control
  reg  [1:0] baud_prescale_sel;
  reg  [2:0] baud_divide_sel;
  reg        char_nine;
  reg        wake_addr;
  reg        rx_bit_nine;
  reg        tx_bit_nine;
  reg        tx_empty_int_en;
  reg        tx_done_int_en;
  reg        rx_int_en;
  reg        line_idle_int_en;
  reg        tx_enable;
  reg        rx_enable;
  reg        rx_standby_req;
  reg        break_send;
  reg  [7:0] serial_data_buffer;
  reg  [7:0] tx_hold;
  // flags
  reg        tx_buffer_empty_flag;
  reg        tx_done_flag;
  reg        rx_buffer_full_flag;
  reg        line_idle_flag;
  reg        overrun_flag;
  reg        noise_flag;
  reg        frame_error_flag;
  reg        rx_armed;
  reg        tx_armed;

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: one-cycle sample enable at 16x bit rate
  reg  [3:0] pre_cnt;
  reg  [6:0] rate_cnt;
  reg  [3:0] pre_max;
  wire       pre_tick;
  wire       samp_tick;
  wire [6:0] rate_max;

  always @* begin
    case (baud_prescale_sel)
      2'h0:    pre_max = `ASRC_PRE1;
      2'h1:    pre_max = `ASRC_PRE3;
      2'h2:    pre_max = `ASRC_PRE4;
      default: pre_max = `ASRC_PRE13;
    endcase
  end

  assign pre_tick  = (pre_cnt == pre_max);
  assign rate_max  = (7'h01 << baud_divide_sel) - 7'h01;
  assign samp_tick = pre_tick & (rate_cnt == rate_max);

  always @(posedge core_clk) begin
    if (!reset_n) begin
      pre_cnt  <= 4'h0;
      rate_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
      if (pre_tick) begin
        rate_cnt <= (rate_cnt >= rate_max) ? 7'h00 : rate_cnt + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  reg  [2:0] rx_state;
  reg  [3:0] samp_cnt;
  reg  [3:0] bit_cnt;
  reg  [2:0] votes;
  reg        prev_in;
  reg        rx_noise;
  reg  [9:0] rx_shift;
  reg        rx_done;
  reg  [7:0] rx_word;
  reg        rx_nine;
  reg        rx_fe;
  reg        rx_nf;
  reg  [7:0] idle_cnt;
  reg        idle_hit;
  wire       bit_val;
  wire [9:0] shift_nxt;
  wire [3:0] last_bit;
  wire [7:0] idle_lim;

  assign bit_val   = maj3(votes);
  assign shift_nxt = {bit_val, rx_shift[9:1]};
  assign last_bit  = char_nine ? 4'h9 : 4'h8;
  assign idle_lim  = char_nine ? `ASRC_IDLE9 : `ASRC_IDLE8;

  always @(posedge core_clk) begin
    if (!reset_n) begin
      rx_state <= RX_IDLE;
      samp_cnt <= 4'h0;
      bit_cnt  <= 4'h0;
      votes    <= 3'h7;
      prev_in  <= 1'b1;
      rx_noise <= 1'b0;
      rx_shift <= 10'h3FF;
      rx_done  <= 1'b0;
      rx_word  <= 8'h00;
      rx_nine  <= 1'b0;
      rx_fe    <= 1'b0;
      rx_nf    <= 1'b0;
      idle_cnt <= 8'h00;
      idle_hit <= 1'b0;
    end else begin
      rx_done  <= 1'b0;
      idle_hit <= 1'b0;
      if (!rx_enable) begin
        rx_state <= RX_IDLE;
        prev_in  <= 1'b1;
        idle_cnt <= 8'h00;
      end else if (samp_tick) begin
        prev_in <= serial_in_pin;
        // high-time counter, fires once per idle stretch
        if (!serial_in_pin) begin
          idle_cnt <= 8'h00;
        end else if (idle_cnt < idle_lim) begin
          idle_cnt <= idle_cnt + 8'h01;
          idle_hit <= (idle_cnt == idle_lim - 8'h01);
        end
        case (rx_state)
          RX_IDLE: begin
            samp_cnt <= 4'h0;
            rx_noise <= 1'b0;
            if (prev_in & !serial_in_pin) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            samp_cnt <= samp_cnt + 4'h1;
            if (samp_cnt >= `ASRC_VOTE_A && samp_cnt <= `ASRC_VOTE_C) begin
              votes <= {votes[1:0], serial_in_pin};
            end
            if (samp_cnt == `ASRC_VOTE_EVAL) begin
              rx_noise <= dis3(votes);
              if (bit_val) begin
                rx_state <= RX_IDLE; // false start rejected
              end
            end
            if (samp_cnt == `ASRC_SAMPLES) begin
              rx_state <= RX_DATA;
              bit_cnt  <= 4'h0;
            end
          end
          RX_DATA: begin
            samp_cnt <= samp_cnt + 4'h1;
            if (samp_cnt >= `ASRC_VOTE_A && samp_cnt <= `ASRC_VOTE_C) begin
              votes <= {votes[1:0], serial_in_pin};
            end
            if (samp_cnt == `ASRC_VOTE_EVAL) begin
              rx_shift <= shift_nxt;
              bit_cnt  <= bit_cnt + 4'h1;
              if (bit_cnt == last_bit) begin
                // stop bit just taken: hand the word over
                rx_state <= RX_IDLE;
                rx_done  <= 1'b1;
                rx_nf    <= rx_noise | dis3(votes);
                rx_fe    <= ~shift_nxt[9];
                rx_word  <= char_nine ? shift_nxt[7:0] : shift_nxt[8:1];
                rx_nine  <= shift_nxt[8];
              end else begin
                rx_noise <= rx_noise | dis3(votes);
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive queue: words wait here until the read buffer is free
  wire        addr_mark;
  wire        rx_push;
  wire        q_ready;
  wire        q_valid;
  wire [10:0] q_data;
  wire        q_pop;

  assign addr_mark = char_nine ? rx_nine : rx_word[7];
  // standby drops words unless an address mark ends it
  assign rx_push = rx_done & (!rx_standby_req | (wake_addr & addr_mark));
  assign q_pop   = q_valid & !rx_buffer_full_flag;

  asrc_fifo #(
    .W  (11),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (rx_push),
    .in_ready  (q_ready),
    .in_data   ({rx_fe, rx_nf, rx_nine, rx_word}),
    .out_valid (q_valid),
    .out_ready (!rx_buffer_full_flag),
    .out_data  (q_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: one bit per 16 sample enables
  reg  [3:0]  tx_div;
  reg  [10:0] tx_shift;
  reg  [3:0]  tx_left;
  reg         tx_full;
  reg         pream_pend;
  reg         brk_tail;
  wire        tx_tick;
  wire [3:0]  tx_len;
  wire [10:0] tx_frame;
  wire        wr_data;
  wire        wr_ctrl2;

  assign tx_tick  = samp_tick & (tx_div == `ASRC_SAMPLES);
  assign tx_len   = char_nine ? 4'hB : 4'hA;
  assign tx_frame = {1'b1, (char_nine ? tx_bit_nine : 1'b1), tx_hold, 1'b0};
  assign wr_data  = bus_wr & (bus_addr == `ASRC_OFF_DATA);
  assign wr_ctrl2 = bus_wr & (bus_addr == `ASRC_OFF_CTRL2);

  always @(posedge core_clk) begin
    if (!reset_n) begin
      tx_div         <= 4'h0;
      tx_shift       <= 11'h7FF;
      tx_left        <= 4'h0;
      tx_full        <= 1'b0;
      pream_pend     <= 1'b0;
      brk_tail       <= 1'b0;
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
    end else begin
      if (samp_tick) begin
        tx_div <= tx_div + 4'h1;
      end
      if (wr_data) begin
        tx_full <= 1'b1;
      end
      if (wr_ctrl2 & bus_wdata[`ASRC_C2_TE] & !tx_enable) begin
        pream_pend <= 1'b1;
      end
      if (wr_ctrl2 & !bus_wdata[`ASRC_C2_SBK] & break_send) begin
        brk_tail <= 1'b1;
      end
      serial_out_oe <= tx_enable | (tx_left != 4'h0);
      if (tx_tick) begin
        if (tx_left != 4'h0) begin
          serial_out_pin <= tx_shift[0];
          tx_shift       <= {1'b1, tx_shift[10:1]};
          tx_left        <= tx_left - 4'h1;
        end else if (tx_enable & pream_pend) begin
          serial_out_pin <= 1'b1;
          tx_shift       <= 11'h7FF;
          tx_left        <= tx_len - 4'h1;
          pream_pend     <= 1'b0;
        end else if (tx_enable & break_send) begin
          serial_out_pin <= 1'b0;
          tx_shift       <= 11'h000;
          tx_left        <= tx_len - 4'h1;
        end else if (brk_tail) begin
          serial_out_pin <= 1'b1;
          brk_tail       <= 1'b0;
        end else if (tx_enable & tx_full & !wr_data) begin
          serial_out_pin <= tx_frame[0];
          tx_shift       <= {1'b1, tx_frame[10:1]};
          tx_left        <= tx_len - 4'h1;
          tx_full        <= 1'b0;
        end else begin
          serial_out_pin <= 1'b1;
        end
      end
    end
  end

  wire tx_load;
  wire tx_quiet;
  assign tx_load  = tx_tick & (tx_left == 4'h0) & tx_enable & !pream_pend &
                    !break_send & !brk_tail & tx_full & !wr_data;
  assign tx_quiet = (tx_left == 4'h0) & !tx_full & !pream_pend & !brk_tail &
                    !break_send;

  ////////////////////////////////////////////////////////////////////////////
  // register access and flags
  wire rd_flags;
  wire rd_data;
  wire rx_clr;
  wire tx_clr;
  wire rx_any;

  assign rd_flags = bus_rd & (bus_addr == `ASRC_OFF_FLAGS);
  assign rd_data  = bus_rd & (bus_addr == `ASRC_OFF_DATA);
  assign rx_any   = rx_buffer_full_flag | line_idle_flag | overrun_flag |
                    noise_flag | frame_error_flag;
  assign rx_clr   = rd_data & rx_armed;
  assign tx_clr   = wr_data & tx_armed;

  // fields that reset leaves alone
  always @(posedge core_clk) begin
    if (bus_wr & (bus_addr == `ASRC_OFF_BAUD)) begin
      baud_divide_sel <= bus_wdata[`ASRC_B_SCR_HI:0];
    end
    if (bus_wr & (bus_addr == `ASRC_OFF_CTRL1)) begin
      tx_bit_nine <= bus_wdata[`ASRC_C1_T8];
      char_nine   <= bus_wdata[`ASRC_C1_M];
      wake_addr   <= bus_wdata[`ASRC_C1_WAKE];
    end
    if (wr_data) begin
      tx_hold <= bus_wdata;
    end
    if (q_pop) begin
      serial_data_buffer <= q_data[7:0];
      rx_bit_nine        <= q_data[8];
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      baud_prescale_sel    <= `ASRC_RST_SCP;
      {tx_empty_int_en, tx_done_int_en, rx_int_en, line_idle_int_en,
       tx_enable, rx_enable, rx_standby_req, break_send} <= `ASRC_RST_CTRL2;
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag         <= 1'b1;
      rx_buffer_full_flag  <= 1'b0;
      line_idle_flag       <= 1'b0;
      overrun_flag         <= 1'b0;
      noise_flag           <= 1'b0;
      frame_error_flag     <= 1'b0;
      rx_armed             <= 1'b0;
      tx_armed             <= 1'b0;
      bus_rdata            <= 8'h00;
      irq_req              <= 1'b0;
    end else begin
      if (bus_wr & (bus_addr == `ASRC_OFF_BAUD)) begin
        baud_prescale_sel <= bus_wdata[`ASRC_B_SCP_HI:`ASRC_B_SCP_LO];
      end
      if (wr_ctrl2) begin
        {tx_empty_int_en, tx_done_int_en, rx_int_en, line_idle_int_en,
         tx_enable, rx_enable, rx_standby_req, break_send} <= bus_wdata;
      end
      // hardware wakeup wins over a same-cycle write
      if (rx_standby_req & wake_addr & rx_done & addr_mark) begin
        rx_standby_req <= 1'b0;
      end else if (rx_standby_req & !wake_addr & idle_hit) begin
        rx_standby_req <= 1'b0;
      end
      // arming: status read with a flag set
      if (rd_flags) begin
        rx_armed <= rx_any;
        tx_armed <= tx_buffer_empty_flag | tx_done_flag;
      end else if (rd_data) begin
        rx_armed <= 1'b0;
      end else if (wr_data) begin
        tx_armed <= 1'b0;
      end
      // receive flags: set wins over clear
      if (rx_clr) begin
        rx_buffer_full_flag <= 1'b0;
        line_idle_flag      <= 1'b0;
        overrun_flag        <= 1'b0;
        noise_flag          <= 1'b0;
        frame_error_flag    <= 1'b0;
      end
      if (q_pop) begin
        rx_buffer_full_flag <= 1'b1;
        noise_flag          <= q_data[9];
        frame_error_flag    <= q_data[10];
      end
      if (rx_push & !q_ready) begin
        overrun_flag <= 1'b1; // word lost, its framing error dropped
      end
      if (idle_hit) begin
        line_idle_flag <= 1'b1;
      end
      // transmit flags
      if (tx_clr) begin
        tx_buffer_empty_flag <= 1'b0;
        tx_done_flag         <= 1'b0;
      end
      if (tx_load) begin
        tx_buffer_empty_flag <= 1'b1;
      end
      if (tx_buffer_empty_flag & tx_quiet & !tx_clr) begin
        tx_done_flag <= 1'b1;
      end
      // read data, registered one cycle after the strobe
      if (bus_rd) begin
        if (bus_addr == `ASRC_OFF_BAUD) begin
          bus_rdata <= {2'h0, baud_prescale_sel, 1'b0, baud_divide_sel};
        end else if (bus_addr == `ASRC_OFF_CTRL1) begin
          bus_rdata <= {rx_bit_nine, tx_bit_nine, 1'b0, char_nine, wake_addr, 3'h0};
        end else if (bus_addr == `ASRC_OFF_CTRL2) begin
          bus_rdata <= {tx_empty_int_en, tx_done_int_en, rx_int_en, line_idle_int_en,
                        tx_enable, rx_enable, rx_standby_req, break_send};
        end else if (bus_addr == `ASRC_OFF_FLAGS) begin
          bus_rdata <= {tx_buffer_empty_flag, tx_done_flag, rx_buffer_full_flag,
                        line_idle_flag, overrun_flag, noise_flag, frame_error_flag, 1'b0};
        end else if (bus_addr == `ASRC_OFF_DATA) begin
          bus_rdata <= serial_data_buffer;
        end else begin
          bus_rdata <= 8'h00;
        end
      end
      // receiver requests need the receiver on and awake
      irq_req <= (tx_empty_int_en & tx_buffer_empty_flag) |
                 (tx_done_int_en & tx_done_flag) |
                 (rx_enable & !rx_standby_req &
                  ((rx_int_en & (rx_buffer_full_flag | overrun_flag)) |
                   (line_idle_int_en & line_idle_flag)));
    end
  end
endmodule

// ### inc/asrc_map.vh
// asrc_map.vh: register map, field positions and counts of the serial port.
// assumes an 8-bit internal data bus with byte addresses.
`ifndef ASRC_MAP_VH
`define ASRC_MAP_VH
// register offsets
`define ASRC_OFF_BAUD   8'h0D
`define ASRC_OFF_CTRL1  8'h0E
`define ASRC_OFF_CTRL2  8'h0F
`define ASRC_OFF_FLAGS  8'h10
`define ASRC_OFF_DATA   8'h11
// serial_control_one fields
`define ASRC_C1_R8      7
`define ASRC_C1_T8      6
`define ASRC_C1_M       4
`define ASRC_C1_WAKE    3
// serial_control_two fields
`define ASRC_C2_TIE     7
`define ASRC_C2_TX_DONE_INT_EN    6
`define ASRC_C2_RIE     5
`define ASRC_C2_LINE_IDLE_INT_EN    4
`define ASRC_C2_TE      3
`define ASRC_C2_RE      2
`define ASRC_C2_RWU     1
`define ASRC_C2_SBK     0
// serial_flags fields
`define ASRC_F_TX_BUFFER_EMPTY_FLAG     7
`define ASRC_F_TC       6
`define ASRC_F_RX_BUFFER_FULL_FLAG     5
`define ASRC_F_IDLE     4
`define ASRC_F_OR       3
`define ASRC_F_NF       2
`define ASRC_F_FE       1
// baud_select fields
`define ASRC_B_SCP_HI   5
`define ASRC_B_SCP_LO   4
`define ASRC_B_SCR_HI   2
// reset values
`define ASRC_RST_CTRL2  8'h00
`define ASRC_RST_SCP    2'h0
// sampling and timing counts
`define ASRC_SAMPLES    4'hF
`define ASRC_VOTE_A     4'h7
`define ASRC_VOTE_C     4'h9
`define ASRC_VOTE_EVAL  4'hA
`define ASRC_IDLE8      8'hA0
`define ASRC_IDLE9      8'hB0
`define ASRC_PRE1       4'h0
`define ASRC_PRE3       4'h2
`define ASRC_PRE4       4'h3
`define ASRC_PRE13      4'hC
`endif

// ### verif/asrc_remote.sv
// asrc_remote.sv: remote serial transmitter driving the receive line.
// assumes the fastest baud setting: one bit is BIT core_clk cycles.
`timescale 1ns/1ps
module asrc_remote #(
  parameter BIT = 16
) (
  input  wire core_clk,
  output reg  line
);
  integer b;
  initial line = 1'b1;
  // one bit of BIT cycles; a one-cycle glitch mid-bit upsets one vote
  task bitout(input val, input nz);
    begin
      line = val;
      repeat (9) @(posedge core_clk);
      #1 line = nz ? ~val : val;
      @(posedge core_clk);
      #1 line = val;
      repeat (BIT - 10) @(posedge core_clk);
      #1;
    end
  endtask
  task send(input [8:0] d, input nine, input stop, input noisy);
    begin
      bitout(1'b0, 1'b0);
      for (b = 0; b < 8; b = b + 1) bitout(d[b], noisy && b == 0);
      if (nine) bitout(d[8], 1'b0);
      bitout(stop, 1'b0);
      line = 1'b1;
    end
  endtask
endmodule

// ### verif/asrc_top_chk.sv
// asrc_top_chk.sv: port checker for the serial port, bound into asrc_top.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module asrc_top_chk (
  // clock and reset
  input wire       core_clk,
  input wire       reset_n,
  // register bus
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire       bus_wr,
  input wire       bus_rd,
  input wire [7:0] bus_rdata,
  // outputs and pins
  input wire       irq_req,
  input wire       serial_in_pin,
  input wire       serial_out_pin,
  input wire       serial_out_oe
);
  reg  [7:0] m2;
  reg  [5:0] mb;
  wire       w2 = bus_wr && bus_addr == 8'h0F;
  wire       fast = mb == 6'h00;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // write mirrors; rwu may be cleared by hardware, so bit 1 is not compared
  always @(posedge core_clk) begin
    if (!reset_n) begin
      m2 <= 8'h00;
      mb[5:4] <= 2'h0;
    end else if (w2) begin
      m2 <= bus_wdata;
    end else if (bus_wr && bus_addr == 8'h0D) begin
      mb <= bus_wdata[5:0];
    end
  end
  sequence tx_on;
    w2 && bus_wdata[3] && fast;
  endsequence
  sequence brk_on;
    w2 && bus_wdata[3] && bus_wdata[0] && fast;
  endsequence
  reset_outputs_a: assert property ($rose(reset_n) |->
    !irq_req && serial_out_pin && !serial_out_oe) else $error("outputs wrong after reset");
  ctrl_readback_a: assert property (bus_rd && bus_addr == 8'h0F |=>
    bus_rdata[7:2] == m2[7:2] && bus_rdata[0] == m2[0]) else $error("control readback");
  no_enable_a: assert property ((m2[7:4] == 4'h0) [*2] |-> !irq_req)
    else $error("interrupt without enable");
  baud_rsvd_a: assert property (bus_rd && bus_addr == 8'h0D |=>
    bus_rdata[7:6] == 2'h0 && !bus_rdata[3]) else $error("baud reserved bits");
  ctrl1_rsvd_a: assert property (bus_rd && bus_addr == 8'h0E |=>
    !bus_rdata[5] && bus_rdata[2:0] == 3'h0) else $error("control one reserved bits");
  flags_rsvd_a: assert property (bus_rd && bus_addr == 8'h10 |=> !bus_rdata[0])
    else $error("flags bit zero");
  unmapped_read_a: assert property (bus_rd && (bus_addr < 8'h0D || bus_addr > 8'h11)
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved");
  tx_drive_a: assert property (tx_on |-> ##[1:40] serial_out_oe)
    else $error("pin not driven");
  preamble_ones_a: assert property ($rose(serial_out_oe) |-> serial_out_pin [*8])
    else $error("preamble not high");
  break_low_a: assert property (brk_on |-> ##[1:400] !serial_out_pin)
    else $error("no break");
endmodule
bind asrc_top asrc_top_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .irq_req(irq_req), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

// ### verif/tb_asrc_top.sv
// tb_asrc_top.sv: register-level tests of the serial port.
// assumes asrc_remote on the receive line and fastest baud.
`timescale 1ns/1ps
module tb_asrc_top;
  reg        core_clk;
  reg        reset_n;
  reg  [7:0] bus_addr;
  reg  [7:0] bus_wdata;
  reg        bus_wr;
  reg        bus_rd;
  wire [7:0] bus_rdata;
  wire       irq_req;
  wire       serial_in_pin;
  wire       serial_out_pin;
  wire       serial_out_oe;
  integer    n_fail;
  integer    total_checks;
  integer    cyc;
  integer    i;
  integer    k;
  reg  [7:0] v;
  reg  [7:0] frame;
  asrc_top DUT (.core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .irq_req(irq_req), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe));
  asrc_remote rem (.core_clk(core_clk), .line(serial_in_pin));
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // each access takes two cycles so strobes never change twice in a step
  task wr(input [7:0] a, input [7:0] d);
    begin
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      tick(1);
      bus_wr = 1'b0;
      tick(1);
    end
  endtask
  task rd(input [7:0] a);
    begin
      bus_addr = a;
      bus_rd = 1'b1;
      tick(1);
      bus_rd = 1'b0;
      v = bus_rdata;
      tick(1);
    end
  endtask
  task wait_full;
    begin
      k = 0;
      rd(8'h10);
      while (v[5] !== 1'b1 && k < 200) begin
        rd(8'h10);
        k = k + 1;
      end
    end
  endtask
  ////////////////////////////////////////
  initial begin
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    reset_n = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    // divide select ignores reset: set it inside reset so the rate counter starts known
    wr(8'h0D, 8'h00);
    reset_n = 1'b1;
    rd(8'h0F); chk(v, 8'h00);
    rd(8'h10); chk(v, 8'hC0);
    rd(8'h0D); chk(v & 8'h30, 8'h00);
    rd(8'h12); chk(v, 8'h00);
    chk({7'h0, irq_req}, 8'h00);
    wr(8'h0F, 8'h80); chk({7'h0, irq_req}, 8'h01);
    wr(8'h0F, 8'h40); chk({7'h0, irq_req}, 8'h01);
    $display("test 1 done");
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h24);
    rem.send(9'h0A5, 1'b0, 1'b1, 1'b0);
    wait_full; chk(v & 8'h2E, 8'h20);
    chk({7'h0, irq_req}, 8'h01);
    rd(8'h11); chk(v, 8'hA5);
    rd(8'h10); chk(v & 8'h20, 8'h00);
    tick(200);
    rd(8'h10); chk(v & 8'h10, 8'h10);
    wr(8'h0F, 8'h34);
    tick(4); chk({7'h0, irq_req}, 8'h01);
    wr(8'h0F, 8'h24);
    tick(4); chk({7'h0, irq_req}, 8'h00);
    rd(8'h11);
    rem.send(9'h03C, 1'b0, 1'b0, 1'b1);
    wait_full; chk(v & 8'h2E, 8'h26);
    rd(8'h11); chk(v, 8'h3C);
    $display("test 2 done");
    wr(8'h0E, 8'h10);
    for (i = 0; i < 2; i = i + 1) begin
      rem.send({i[0], 8'h5A}, 1'b1, 1'b1, 1'b0);
      wait_full;
      rd(8'h0E); chk(v & 8'h90, {i[0], 7'h10});
      rd(8'h11); chk(v, 8'h5A);
    end
    wr(8'h0E, 8'h18);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    rd(8'h0E); chk(v & 8'h18, 8'h18);
    rd(8'h0F); chk(v, 8'h00);
    $display("test 3 done");
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h24);
    for (i = 0; i < 18; i = i + 1) rem.send(i[8:0], 1'b0, i < 17, 1'b0);
    tick(20);
    rd(8'h10); chk(v & 8'h2E, 8'h28);
    for (i = 0; i < 17; i = i + 1) begin
      rd(8'h10);
      rd(8'h11); chk(v, i[7:0]);
    end
    rd(8'h10); chk(v & 8'h2E, 8'h00);
    $display("test 4 done");
    wr(8'h0E, 8'h08);
    wr(8'h0F, 8'h26);
    rem.send(9'h011, 1'b0, 1'b1, 1'b0);
    tick(20);
    rd(8'h10); chk(v & 8'h20, 8'h00);
    chk({7'h0, irq_req}, 8'h00);
    rem.send(9'h081, 1'b0, 1'b1, 1'b0);
    tick(20);
    rd(8'h0F); chk(v, 8'h24);
    wr(8'h0F, 8'h20);
    tick(4); chk({7'h0, irq_req}, 8'h00);
    rd(8'h10); chk(v & 8'h20, 8'h20);
    rd(8'h11); chk(v, 8'h81);
    wr(8'h0E, 8'h00);
    wr(8'h0F, 8'h26);
    rem.send(9'h011, 1'b0, 1'b1, 1'b0);
    rd(8'h0F); chk(v, 8'h26);
    tick(220);
    rd(8'h0F); chk(v, 8'h24);
    $display("test 5 done");
    wr(8'h0F, 8'h08);
    wr(8'h11, 8'h55);
    k = 0;
    while (serial_out_pin !== 1'b0 && k < 400) begin
      tick(1);
      k = k + 1;
    end
    chk({7'h0, k > 140 && k < 180}, 8'h01);
    chk({7'h0, serial_out_oe}, 8'h01);
    tick(8); chk({7'h0, serial_out_pin}, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      tick(16);
      frame[i] = serial_out_pin;
    end
    chk(frame, 8'h55);
    tick(16); chk({7'h0, serial_out_pin}, 8'h01);
    wr(8'h0F, 8'h09);
    tick(400); chk({7'h0, serial_out_pin}, 8'h00);
    wr(8'h0F, 8'h08);
    tick(220); chk({7'h0, serial_out_pin}, 8'h01);
    $display("test 6 done");
    report_and_stop;
  end
endmodule
